// >>> sba_pkg.sv
/*
 * Shared constants for the secondary bus arbiter.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
package sba_pkg;
    // ========================================
    // Sizes
    localparam int NUM_EXT = 9;           // External requesters
    localparam int NUM_REQ = NUM_EXT + 1; // Plus the bridge itself
    localparam int REQ_IDX_W = 4;         // Index width
    localparam logic [REQ_IDX_W-1:0] BRIDGE_IDX = 4'h9; // Bridge slot in the vector
    localparam logic [REQ_IDX_W-1:0] IDX_ZERO = 4'h0;
    localparam logic [REQ_IDX_W-1:0] IDX_ONE = 4'h1;
    localparam logic [REQ_IDX_W-1:0] IDX_LAST = 4'h9;
    // ========================================
    // Reset values
    localparam logic [NUM_EXT-1:0] EXT_IDLE = 9'h1ff;  // All active-low lines released
    localparam logic [NUM_REQ-1:0] NONE_REQ = 10'h000;
    // ========================================
    // Arbiter states
    typedef enum logic [1:0] {
        SBA_IDLE = 2'b00,
        SBA_GRANT = 2'b01,
        SBA_BUSY = 2'b10
    } sba_state_t;
endpackage

// >>> sba_grp_if.sv
/*
 * Carrier between the arbiter top and its group picker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sba_grp_if #(parameter int N = 10, parameter int W = 4);
    logic [N-1:0] req;    // Requests of this group
    logic [W-1:0] last;   // Most recent winner of this group
    logic hit;            // Some request present
    logic [W-1:0] winner; // Chosen index
    modport top (output req, output last, input hit, input winner);
    modport pick (input req, input last, output hit, output winner);
endinterface

// >>> sba_rr_pick.sv
/*
 * Round-robin picker for one priority group.
 * Assumes the caller holds the index of the group's last winner.
 */
`timescale 1ns/1ps
module sba_rr_pick #(
    parameter int N = 10,
    parameter int W = 4
) (
    sba_grp_if.pick grp // Group requests and result
);
    // ========================================
    // Search starts just past the last winner, so it ranks lowest [R13]
    logic [W-1:0] found;
    logic any;
    always_comb begin
        logic [W-1:0] idx;
        idx = '0;
        found = '0;
        any = 1'b0;
        for (int k = N; k >= 1; k--) begin
            idx = W'((int'(grp.last) + k) % N);
            if (grp.req[idx]) begin
                found = idx; // Smallest k wins, loop ends on it
                any = 1'b1;
            end
        end
    end
    assign grp.hit = any;
    assign grp.winner = found;
endmodule // sba_rr_pick

// >>> sba_arbiter.sv
/*
 * Secondary bus arbiter: two-level rotating priority over nine external
 * masters and the bridge, with a strap that hands arbitration to an
 * external arbiter. Assumes bus idle and bridge request come from the
 * bridge's own bus engine, already synchronous to clk.
 */
`timescale 1ns/1ps
// How it works
// [R1] Nine active-low request inputs 8..0 plus the bridge's own internal request.
// [R2] Two rotating groups; each requester individually assigned high or low.
// [R3] A master drives its request low when it wants the bus.
// [R4] At most one of nine grants; granted master starts once bus idle.
// [R5] Bridge request and grant are internal signals, no pins.
// [R6] Strap low enables internal arbiter; strap high disables it.
// [R7] With arbiter disabled an external arbiter decides for the bridge.
// [R8] Disabled: request line 0 is bridge grant input; start when idle.
// [R9] Disabled: grant line 0 is the bridge's request output.
// [R10] External mode: park when granted, bus idle, nothing to do.
// [R11] Parked: parity driven valid one cycle after address/data lines.
// [R12] Grants, internal one included, are one-hot or all idle.
// [R13] Latest winner in a group drops to that group's lowest position.
module sba_arbiter #(
    parameter int NUM_EXT = sba_pkg::NUM_EXT // External requesters
) (
    input wire logic clk,                          // 50 MHz bus clock
    input wire logic srst,                         // Sync reset, active high
    input wire logic cfnStrapLow,                  // Strap: low enables arbiter
    input wire logic [8:0] reqExtN,                // Request lines, active low
    input wire logic bridgeReq,                    // Bridge wants the bus
    input wire logic busIdle,                      // Bus idle this cycle
    input wire logic [sba_pkg::NUM_REQ-1:0] hiPri, // 1 = high group
    output logic [8:0] gntExtN,                    // Grant lines, active low
    output logic bridgeGnt,                        // Bridge may start
    output logic bridgeStart,                      // Bridge starts now (pulse)
    output logic parkAdOe,                         // Drive address/data to park
    output logic parkParOe,                        // Drive parity while parked
    output logic extMode                           // External arbiter selected
);
    localparam int N = sba_pkg::NUM_REQ;
    localparam int W = sba_pkg::REQ_IDX_W;

    // ========================================
    // Strap capture: sampled during reset as well, so the first edge after
    // release already knows the mode and no internal grant leaks out while
    // an external arbiter owns the grant lines
    logic extMode_reg;
    always_ff @(posedge clk) begin
        extMode_reg <= cfnStrapLow; // [R6] high strap means external arbiter
    end

    // ========================================
    // Request vector: bit 9 is the bridge, internal only
    logic [N-1:0] reqVec;
    assign reqVec = {bridgeReq, ~reqExtN}; // [R1] [R3] [R5] low is asserted

    logic [N-1:0] hiReq;
    logic [N-1:0] loReq;
    assign hiReq = reqVec & hiPri;  // [R2]
    assign loReq = reqVec & ~hiPri; // [R2]

    // ========================================
    // Group pickers
    sba_grp_if #(.N(N), .W(W)) hiGrp ();
    sba_grp_if #(.N(N), .W(W)) loGrp ();
    logic [W-1:0] hiLast_reg;
    logic [W-1:0] loLast_reg;
    assign hiGrp.req = hiReq;
    assign hiGrp.last = hiLast_reg;
    assign loGrp.req = loReq;
    assign loGrp.last = loLast_reg;
    sba_rr_pick #(.N(N), .W(W)) uHi (.grp(hiGrp));
    sba_rr_pick #(.N(N), .W(W)) uLo (.grp(loGrp));

    // High group always beats low group
    logic anyReq;
    logic [W-1:0] pickIdx;
    logic pickHi;
    assign anyReq = hiGrp.hit | loGrp.hit;
    assign pickHi = hiGrp.hit; // [R2]
    assign pickIdx = pickHi ? hiGrp.winner : loGrp.winner;

    // ========================================
    // Internal arbiter state
    sba_pkg::sba_state_t state_reg;
    sba_pkg::sba_state_t state_next;
    logic [W-1:0] owner_reg;
    logic [W-1:0] owner_next;
    logic ownerReq;
    assign ownerReq = reqVec[owner_reg];

    // Grant holds until the owner starts (bus leaves idle) or drops request;
    // re-arbitration happens only from IDLE; GRANT goes to BUSY on a busy bus, BUSY returns to IDLE on an idle bus,
    // GRANT returns to IDLE on an idle bus once the owner drops request, so grants never overlap.
    always_comb begin
        state_next = state_reg;
        owner_next = owner_reg;
        unique case (state_reg)
            sba_pkg::SBA_IDLE: begin
                if (anyReq) begin
                    state_next = sba_pkg::SBA_GRANT;
                    owner_next = pickIdx;
                end
            end
            sba_pkg::SBA_GRANT: begin
                if (!busIdle) state_next = sba_pkg::SBA_BUSY; // [R4] owner started
                else if (!ownerReq) state_next = sba_pkg::SBA_IDLE;
            end
            sba_pkg::SBA_BUSY: begin
                if (busIdle) state_next = sba_pkg::SBA_IDLE;
            end
            default: state_next = sba_pkg::SBA_IDLE;
        endcase
        if (extMode_reg) state_next = sba_pkg::SBA_IDLE;
    end

    // Winner rotation updated on each new grant [R13]
    logic newGrant;
    assign newGrant = !extMode_reg && state_reg == sba_pkg::SBA_IDLE && anyReq;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= sba_pkg::SBA_IDLE;
            owner_reg <= sba_pkg::IDX_ZERO;
        end else begin
            state_reg <= state_next;
            owner_reg <= owner_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hiLast_reg <= sba_pkg::IDX_LAST;
            loLast_reg <= sba_pkg::IDX_LAST;
        end else if (newGrant && pickHi) begin
            hiLast_reg <= pickIdx; // [R13]
        end else if (newGrant) begin
            loLast_reg <= pickIdx; // [R13]
        end
    end

    // ========================================
    // Grant decode: one owner index gives a one-hot vector [R12]
    logic intGranting;
    logic [N-1:0] intGntVec;
    assign intGranting = state_next == sba_pkg::SBA_GRANT;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gGnt
            assign intGntVec[g] = intGranting && owner_next == W'(g); // [R4] [R12]
        end
    endgenerate

    // ========================================
    // External arbiter mode: line 0 swaps roles
    logic extGntIn;
    assign extGntIn = ~reqExtN[0]; // [R7] [R8]

    logic [8:0] gntExtN_next;
    logic bridgeGnt_next;
    assign gntExtN_next = extMode_reg ?
        {sba_pkg::EXT_IDLE[8:1], ~bridgeReq} :  // [R9] line 0 is bridge request out
        ~intGntVec[8:0];
    assign bridgeGnt_next = extMode_reg ? extGntIn : intGntVec[sba_pkg::BRIDGE_IDX];

    // Parking: granted, idle bus, nothing to do [R10]
    logic parkNext;
    assign parkNext = bridgeGnt_next && busIdle && !bridgeReq;

    always_ff @(posedge clk) begin
        if (srst) begin
            gntExtN <= sba_pkg::EXT_IDLE;
            bridgeGnt <= 1'b0;
            bridgeStart <= 1'b0;
            parkAdOe <= 1'b0;
            parkParOe <= 1'b0;
            extMode <= 1'b0;
        end else begin
            gntExtN <= gntExtN_next;
            bridgeGnt <= bridgeGnt_next;
            bridgeStart <= bridgeGnt_next && busIdle && bridgeReq; // [R8]
            parkAdOe <= parkNext; // [R10]
            parkParOe <= parkAdOe && parkNext; // [R11] one cycle behind
            extMode <= extMode_reg;
        end
    end
endmodule // sba_arbiter

// >>> sba_arbiter_asserts.sv
/* Port-level checker for sba_arbiter.
   Assumes one clock and a strap that changes only while srst is high. */
`timescale 1ns/1ps
module sba_arbiter_asserts (
    input wire logic clk, // Bus clock
    input wire logic srst, // Sync reset
    input wire logic [8:0] reqExtN, // Request lines
    input wire logic bridgeReq, // Bridge wants bus
    input wire logic busIdle, // Bus idle
    input wire logic [8:0] gntExtN, // Grant lines
    input wire logic bridgeGnt, // Bridge grant
    input wire logic bridgeStart, // Bridge start
    input wire logic parkAdOe, // Park data lines
    input wire logic parkParOe, // Park parity
    input wire logic extMode // External arbiter
);
    // ========================================
    // Grant and parking relations, all on the one clock
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_ONE_GNT: assert property (!extMode |-> $onehot0({~gntExtN, bridgeGnt}))
        else $error("more than one grant");
    AST_EXT_GNT: assert property (extMode && $past(extMode) |->
        bridgeGnt == !$past(reqExtN[0])) else $error("grant input not followed");
    AST_NEW_GNT: assert property (!extMode |->
        (~gntExtN & $past(gntExtN) & $past(reqExtN)) == 9'h000)
        else $error("grant without request");
    AST_BUSY_DROP: assert property (!extMode && gntExtN != 9'h1ff && !busIdle |=>
        gntExtN == 9'h1ff) else $error("grant kept on busy bus");
    AST_EXT_IDLE: assert property (extMode |-> gntExtN[8:1] == 8'hff)
        else $error("internal grant in external mode");
    AST_EXT_REQ: assert property (extMode && $past(extMode) |->
        gntExtN[0] == !$past(bridgeReq)) else $error("request output wrong");
    AST_PARK: assert property (extMode && !reqExtN[0] && busIdle && !bridgeReq |=>
        parkAdOe) else $error("bus not parked");
    AST_PAR_LAG: assert property ($rose(parkAdOe) |-> !parkParOe ##1 (parkParOe == parkAdOe))
        else $error("parity drive not one cycle behind");
    AST_PAR_ONLY: assert property (parkParOe |-> parkAdOe && $past(parkAdOe))
        else $error("parity driven without parked data lines");
    AST_START: assert property (bridgeStart |-> $past(bridgeReq) && $past(busIdle))
        else $error("bridge start without cause");
endmodule // sba_arbiter_asserts
bind sba_arbiter sba_arbiter_asserts chk (.clk, .srst, .reqExtN, .bridgeReq, .busIdle,
    .gntExtN, .bridgeGnt, .bridgeStart, .parkAdOe, .parkParOe, .extMode);

// >>> sba_master_model.sv
/* Behavioural secondary-bus masters and external arbiter.
   Assumes the bench changes want, extArb, park and stall off the clock edge. */
`timescale 1ns/1ps
module sba_master_model (
    input wire logic [8:0] want, // Masters wanting the bus
    input wire logic extArb, // Arbitration done outside
    input wire logic park, // Outside arbiter parks on the bridge
    input wire logic stall, // Outside arbiter withholds the grant
    input wire logic [8:0] gntExtN, // Grants from the design
    output logic [8:0] reqExtN // Request lines, active low
);
    // ========================================
    // Masters pull low to ask; outside arbiter answers on line 0, promptly or never
    assign reqExtN[8:1] = ~want[8:1];
    assign reqExtN[0] = extArb ? ~(park | (~gntExtN[0] & ~stall)) : ~want[0];
endmodule // sba_master_model

// >>> test_sba_arbiter.sv
/* Testbench for sba_arbiter: rotation, priority groups, external mode and parking.
   Assumes registered outputs settle one edge after the inputs that cause them. */
`timescale 1ns/1ps
module test_sba_arbiter;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cfnStrapLow = 1'b0;
    logic bridgeReq = 1'b0;
    logic busIdle = 1'b1;
    logic [9:0] hiPri = 10'h000;
    logic [8:0] want = 9'h000;
    logic extArb = 1'b0;
    logic park = 1'b0;
    logic stall = 1'b0;
    logic [8:0] reqExtN, gntExtN;
    logic bridgeGnt, bridgeStart, parkAdOe, parkParOe, extMode, seenStart;
    logic [3:0] idx;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [9:0] hiMask [5] = '{10'h020, 10'h020, 10'h084, 10'h084, 10'h084};
    logic [9:0] hiExp [5] = '{10'h005, 10'h005, 10'h007, 10'h002, 10'h007};
    sba_arbiter dut (.clk, .srst, .cfnStrapLow, .reqExtN, .bridgeReq, .busIdle, .hiPri,
        .gntExtN, .bridgeGnt, .bridgeStart, .parkAdOe, .parkParOe, .extMode);
    sba_master_model mst (.want, .extArb, .park, .stall, .gntExtN, .reqExtN);
    always #10 clk = ~clk;
    // ========================================
    // Hang guard: the tests need under a hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Strap only moves under reset, as a board strap would
    task automatic restart(input logic strap);
        srst = 1'b1;
        cfnStrapLow = strap;
        extArb = strap;
        repeat (5) @(negedge clk);
        srst = 1'b0;
    endtask
    // Wait for one grant, then run one busy cycle so the arbiter goes round
    task automatic win(output logic [3:0] who);
        who = 4'hf;
        for (int i = 0; i < 20 && who == 4'hf; i++) begin
            @(negedge clk);
            if (bridgeGnt === 1'b1) who = 4'h9;
            for (int b = 0; b < 9; b++) if (gntExtN[b] === 1'b0) who = b[3:0];
        end
        busIdle = 1'b0;
        @(negedge clk);
        busIdle = 1'b1;
    endtask
    initial begin
        restart(1'b0);
        check("grants after reset", {bridgeGnt, gntExtN}, 10'h1ff);
        want = 9'h1ff;
        bridgeReq = 1'b1;
        for (int k = 0; k < 11; k++) begin
            win(idx);
            check("low group rotation", 10'(idx), 10'(k % 10));
        end
        $display("rotation test done");
        for (int k = 0; k < 5; k++) begin
            hiPri = hiMask[k];
            win(idx);
            check("high group order", 10'(idx), hiExp[k]);
        end
        $display("priority test done");
        bridgeReq = 1'b0;
        want = 9'h1fe;
        stall = 1'b1;
        restart(1'b1);
        repeat (3) @(negedge clk);
        check("external mode flag", 10'(extMode), 10'h001);
        bridgeReq = 1'b1;
        repeat (3) @(negedge clk);
        check("request output", 10'(gntExtN), 10'h1fe);
        check("start while withheld", 10'(bridgeStart), 10'h000);
        stall = 1'b0;
        @(negedge clk);
        seenStart = bridgeStart;
        check("bridge grant input", 10'(bridgeGnt), 10'h001);
        @(negedge clk);
        check("bridge start", 10'(seenStart | bridgeStart), 10'h001);
        bridgeReq = 1'b0;
        park = 1'b1;
        @(negedge clk);
        check("park address lines", 10'({parkParOe, parkAdOe}), 10'h001);
        @(negedge clk);
        check("park parity", 10'({parkParOe, parkAdOe}), 10'h003);
        $display("external mode test done");
        give_verdict();
    end
endmodule // test_sba_arbiter
